// ===== hdl/sar_pkg.sv
/*
 Shared constants of the serial readout of the successive-approximation converter.
 Assumes nothing of its surroundings; imported by sar_buf and sar_adc_readout.
*/
package sar_pkg;
	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS = 16;
	localparam int LEAD_ZEROS = 4;
	localparam int RES_BITS_DEFAULT = 12;
	localparam logic [4:0] CNT_RESET = 5'h00;
	localparam logic [4:0] CNT_LAST = 5'h10;
	localparam logic [4:0] CNT_FIRST_RESULT = 5'h04;
	// ****************************************
	// Timing of the far side
	// ****************************************
	localparam int QUIET_TIME_NS = 50;
	localparam int CORE_CLK_PERIOD_NS = 25;
	localparam int QUIET_CYCLES = (QUIET_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
	// ****************************************
	// Buffer and reset values
	// ****************************************
	localparam int BUF_DEPTH = 2;
	localparam logic CS_IDLE = 1'b1;
	typedef enum logic {SAR_TRACK, SAR_HOLD} sar_core_state_type;
endpackage

// ===== hdl/sar_stream_if.sv
/*
 Valid/ready carrier for words between the design's own modules.
 Assumes one clock for both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface sar_stream_if #(parameter int WIDTH = 12);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport dst (input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== hdl/sar_buf.sv
/*
 Small FIFO of parameter width and depth with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_buf import sar_pkg::*; #(
	parameter int WIDTH = RES_BITS_DEFAULT,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	sar_stream_if.dst fill,
	sar_stream_if.src drain
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [CW-1:0] count_reg, count_next;
	logic in_ready_reg, in_ready_next;
	logic push, pop;

	assign fill.ready = in_ready_reg;
	assign drain.valid = (count_reg != '0);
	assign drain.data = mem_reg[rd_ptr_reg];

	always_comb begin
		push = fill.valid & in_ready_reg;
		pop = drain.ready & (count_reg != '0);
		mem_next = mem_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		if (push) begin
			mem_next[wr_ptr_reg] = fill.data;
			wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
		end
		if (pop) begin
			rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
		end
		count_next = count_reg + CW'(push) - CW'(pop);
		// Ready only from a register, so a stalled drain really fills the buffer
		in_ready_next = (count_next != CW'(DEPTH));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready_reg <= 1'b1;
		end else begin
			mem_reg <= mem_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			in_ready_reg <= in_ready_next;
		end
	end
endmodule // sar_buf
`default_nettype wire

// ===== hdl/sar_adc_readout.sv
/*
 Conversion control and serial readout of a single-channel successive-approximation
 converter. The core side tracks a stream of input levels; the link side converts
 and shifts the result out on the serial clock.
 Assumes an external master drives the frame select and the serial clock, and that
 the serial clock idles between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_adc_readout import sar_pkg::*; #(
	parameter int RES_BITS = RES_BITS_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [RES_BITS-1:0] track_data,
	input wire logic track_valid,
	output wire logic track_ready,
	output logic serial_result_out,
	output logic serial_result_oe
);
	// ****************************************
	// Input tracking buffer
	// ****************************************
	sar_stream_if #(.WIDTH(RES_BITS)) fill_if ();
	sar_stream_if #(.WIDTH(RES_BITS)) drain_if ();

	assign fill_if.data = track_data;
	assign fill_if.valid = track_valid;
	assign track_ready = fill_if.ready;

	sar_buf #(
		.WIDTH(RES_BITS),
		.DEPTH(BUF_DEPTH)
	) u_track_buf (
		.clk(core_clk),
		.rst_n(rst_n),
		.fill(fill_if),
		.drain(drain_if)
	);

	// ****************************************
	// Core domain: track and hold
	// ****************************************
	sar_core_state_type state_reg, state_next;
	logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
	logic done_meta_reg, done_sync_reg;
	logic [RES_BITS-1:0] track_word_reg, track_word_next;
	logic [RES_BITS-1:0] hold_word_reg, hold_word_next;
	logic held_flag_reg, held_flag_next;
	logic oe_reg, oe_next;
	logic cs_fall;
	logic link_done_reg;

	assign drain_if.ready = (state_reg == SAR_TRACK);

	always_comb begin
		state_next = state_reg;
		track_word_next = track_word_reg;
		hold_word_next = hold_word_reg;
		held_flag_next = held_flag_reg;
		// Low on the pin means addressed
		cs_fall = cs_prev_reg & ~cs_sync_reg;
		// Released while deselected, driven once selected
		oe_next = ~cs_sync_reg;
		unique case (state_reg)
			SAR_TRACK: begin
				if (drain_if.valid) begin
					track_word_next = drain_if.data;
				end
				// Hold the tracked level at the falling frame select
				if (cs_fall) begin
					hold_word_next = track_word_reg;
					held_flag_next = 1'b1;
					state_next = SAR_HOLD;
				end
			end
			SAR_HOLD: begin
				// Back to tracking at conversion end or an aborted frame
				if (done_sync_reg | cs_sync_reg) begin
					held_flag_next = 1'b0;
					state_next = SAR_TRACK;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SAR_TRACK;
			cs_meta_reg <= CS_IDLE;
			cs_sync_reg <= CS_IDLE;
			cs_prev_reg <= CS_IDLE;
			done_meta_reg <= 1'b0;
			done_sync_reg <= 1'b0;
			track_word_reg <= '0;
			hold_word_reg <= '0;
			held_flag_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cs_meta_reg <= cs_n;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
			done_meta_reg <= link_done_reg;
			done_sync_reg <= done_meta_reg;
			track_word_reg <= track_word_next;
			hold_word_reg <= hold_word_next;
			held_flag_reg <= held_flag_next;
			oe_reg <= oe_next;
		end
	end

	assign serial_result_oe = oe_reg;

	// ****************************************
	// Link domain: approximation and shifting
	// ****************************************
	// Deselect ends the frame without needing a serial clock edge
	logic link_rst_n;
	logic flag_meta_reg, flag_sync_reg;
	logic [4:0] bit_cnt_reg, bit_cnt_next;
	logic [RES_BITS-1:0] approx_reg, approx_next;
	logic [RES_BITS-1:0] mask_reg, mask_next;
	logic [RES_BITS-1:0] trial;
	logic sdo_reg, sdo_next;
	logic link_done_next;
	logic keep;

	assign link_rst_n = rst_n & ~cs_n;

	always_comb begin
		bit_cnt_next = (bit_cnt_reg == CNT_LAST) ? bit_cnt_reg : bit_cnt_reg + 5'h01;
		approx_next = approx_reg;
		mask_next = mask_reg;
		link_done_next = link_done_reg;
		trial = approx_reg | mask_reg;
		// Comparing against each binary weight gives straight binary code
		keep = flag_sync_reg & (trial <= hold_word_reg);
		// Leading and trailing positions shift zeros
		sdo_next = 1'b0;
		// One decision per falling serial clock edge
		if (bit_cnt_next >= CNT_FIRST_RESULT && mask_reg != '0) begin
			sdo_next = keep;
			mask_next = mask_reg >> 1;
			if (keep) begin
				approx_next = trial;
			end
			if (mask_reg == RES_BITS'(1)) begin
				link_done_next = 1'b1;
			end
		end
	end

	// Hold word is read only after its flag passed two stages here
	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			flag_meta_reg <= 1'b0;
			flag_sync_reg <= 1'b0;
			bit_cnt_reg <= CNT_RESET;
			approx_reg <= '0;
			mask_reg <= {1'b1, {(RES_BITS-1){1'b0}}};
			sdo_reg <= 1'b0;
			link_done_reg <= 1'b0;
		end else begin
			flag_meta_reg <= held_flag_reg;
			flag_sync_reg <= flag_meta_reg;
			bit_cnt_reg <= bit_cnt_next;
			approx_reg <= approx_next;
			mask_reg <= mask_next;
			sdo_reg <= sdo_next;
			link_done_reg <= link_done_next;
		end
	end

	assign serial_result_out = sdo_reg;
endmodule // sar_adc_readout
`default_nettype wire

// ===== sim/sar_master_model.sv
/* Serial master on the far side of the readout.
 Assumes the bench calls frame; sclk idles high between frames. */
`timescale 1ns/1ps
`default_nettype none
module sar_master_model (
	output logic sclk = 1'b1,
	output logic cs_n = 1'b1,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic last_bit = 1'b0;
	task automatic frame(output logic [15:0] word);
		#7 cs_n = 1'b0;
		#200;
		for (int i = 0; i < 16; i++) begin
			// Released line reads inverted, never a lucky match
			last_bit = serial_result_oe ? serial_result_out : ~last_bit;
			word = {word[14:0], last_bit};
			#24 sclk = 1'b0;
			#24 sclk = 1'b1;
		end
		#24 cs_n = 1'b1;
		#75;
	endtask
endmodule // sar_master_model
`default_nettype wire

// ===== sim/sar_adc_readout_props.sv
/* Port checks of the serial readout.
 Assumes a bind onto sar_adc_readout. */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_readout_props import sar_pkg::*; #(
	parameter int RES_BITS = RES_BITS_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic track_valid,
	input wire logic track_ready,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic [4:0] fall_reg, fall_next;
	always_comb fall_next = (fall_reg == 5'h1F) ? fall_reg : fall_reg + 5'h01;
	always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
		// Count restarts with every frame, so padding is judged per frame
		if (!rst_n || cs_n) begin
			fall_reg <= 5'h00;
		end else begin
			fall_reg <= fall_next;
		end
	end
	AST_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		cs_n |-> !serial_result_out) else $error("Idle drive");
	AST_OE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		cs_n [*5] |-> !serial_result_oe) else $error("Late release");
	AST_OE_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
		!cs_n [*5] |-> serial_result_oe) else $error("No enable");
	AST_OE_RISE: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(serial_result_oe) |-> !cs_n && !$past(cs_n, 2)) else $error("Bad rise");
	AST_OE_FALL: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(serial_result_oe) |-> cs_n && $past(cs_n, 2)) else $error("Bad fall");
	AST_TRACK: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cs_n && !track_valid) [*8] |-> track_ready) else $error("Not tracking");
	AST_FULL: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(track_ready) |-> $past(track_valid)) else $error("Bad stall");
	AST_PAD: assert property (@(posedge sclk) disable iff (cs_n)
		(fall_reg < 5'h04 || int'(fall_reg) >= LEAD_ZEROS + RES_BITS) |-> !serial_result_out) else $error("Pad");
	cover property (@(posedge core_clk) $fell(track_ready));
	cover property (@(posedge core_clk) $rose(serial_result_oe));
	cover property (@(posedge sclk) fall_reg == 5'h10);
endmodule // sar_adc_readout_props
`default_nettype wire

// ===== sim/sar_adc_readout_test.sv
/* Bench of the 12-bit and 10-bit readouts, each with a master model.
 Assumes sar_master_model drives the link. */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_readout_test;
	localparam logic [27:0] ROWS [3] = '{{12'h000, 16'h0000}, {12'hFFF, 16'h0FFF}, {12'h801, 16'h0801}};
	logic core_clk, rst_n, sclk, cs_n, track_valid, track_ready, serial_result_out, serial_result_oe;
	logic [11:0] track_data;
	logic [15:0] word;
	logic sclk10, cs_n10, track_ready10, serial_result_out10, serial_result_oe10;
	logic [15:0] word10;
	int miscompares = 0, cmp_count = 0;
	sar_adc_readout dut (.core_clk, .rst_n, .sclk, .cs_n, .track_data, .track_valid, .track_ready,
		.serial_result_out, .serial_result_oe);
	sar_master_model mst (.sclk, .cs_n, .serial_result_out, .serial_result_oe);
	// Short variant shares the stream and takes its upper ten bits
	sar_adc_readout #(.RES_BITS(10)) dut10 (.core_clk, .rst_n, .sclk(sclk10), .cs_n(cs_n10),
		.track_data(track_data[11:2]), .track_valid, .track_ready(track_ready10),
		.serial_result_out(serial_result_out10), .serial_result_oe(serial_result_oe10));
	sar_master_model mst10 (.sclk(sclk10), .cs_n(cs_n10), .serial_result_out(serial_result_out10),
		.serial_result_oe(serial_result_oe10));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("Compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic offer(input logic [11:0] code);
		int n;
		track_data = code;
		track_valid = 1'b1;
		for (n = 0; track_ready !== 1'b1 && n < 50; n++) @(negedge core_clk);
		if (n == 50) begin
			miscompares++;
			complete_run();
		end
		repeat (3) @(negedge core_clk);
	endtask
	task automatic run(input logic [11:0] code, input logic [15:0] exp);
		offer(code);
		mst.frame(word);
		mst10.frame(word10);
		@(negedge core_clk);
		check(word, exp);
		check(word10, {4'h0, code[11:2], 2'h0});
		track_valid = 1'b0;
		repeat (10) @(negedge core_clk);
		$display("Frame %h done", code);
	endtask
	initial begin
		rst_n = 1'b0;
		track_valid = 1'b0;
		track_data = 12'h000;
		repeat (20) @(negedge core_clk);
		check({10'h000, track_ready10, serial_result_oe10, serial_result_out10, track_ready, serial_result_oe,
			serial_result_out}, 16'h0024);
		rst_n = 1'b1;
		$display("Reset done");
		for (int i = 0; i < 3; i++) begin
			run(ROWS[i][27:16], ROWS[i][15:0]);
		end
		offer(12'hA5A);
		track_valid = 1'b0;
		fork
			mst.frame(word);
			begin
				repeat (12) @(negedge core_clk);
				offer(12'h5A5);
			end
		join
		@(negedge core_clk);
		check(word, 16'h0A5A);
		$display("Overlap test done");
		run(12'h5A5, 16'h05A5);
		// Mid-run reset while idle, then a frame to show recovery
		rst_n = 1'b0;
		repeat (3) @(negedge core_clk);
		check({10'h000, track_ready10, serial_result_oe10, serial_result_out10, track_ready, serial_result_oe,
			serial_result_out}, 16'h0024);
		rst_n = 1'b1;
		run(12'h3C3, 16'h03C3);
		$display("Second reset done");
		complete_run();
	end
endmodule // sar_adc_readout_test
bind sar_adc_readout sar_adc_readout_props #(.RES_BITS(RES_BITS)) props (.core_clk, .rst_n, .sclk, .cs_n,
	.track_valid, .track_ready, .serial_result_out, .serial_result_oe);
`default_nettype wire
